// >>> hw/mhsm_monitor.sv
/*
 Health supervision, self-test sequencer, lamp and fault digit, link
 setup registers and Avalon-MM slave of the scale interface module.
 Assumes all inputs synchronous to clk; the self-test responder answers
 each request with st_ack.
*/
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mhsm_regs.svh"

module mhsm_monitor
#(
   parameter int WDOG_CYCLES = `MHSM_WDOG_TIME_MS * `MHSM_CLK_MHZ * 1000
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   // local processor and health inputs, halt and enable outputs
   input  wire logic        wdog_kick,
   input  wire logic        sys_wdog_fail,
   input  wire logic        power_fail,
   input  wire logic        msg_arrive,
   output logic             cpu_halt_irq,
   output logic             host_mem_enable,
   output logic             rx_data_enable,
   // self-test responder
   output logic             st_req,
   output var  logic [3:0]  st_unit,
   input  wire logic        st_ack,
   input  wire logic        st_fail,
   // serial link setup
   output var  logic [15:0] link_baud,
   output var  logic        link_load,
   // front panel
   output logic             status_lamp,
   output mhsm_pkg::mhsm_digit_t digit
);

   localparam int WW = $clog2(WDOG_CYCLES + 1);
   localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_CYCLES - 1);

   mhsm_pkg::mhsm_st_t    st_q;
   logic [3:0]            st_unit_q;
   logic [3:0]            fail_code_q;
   logic [WW-1:0]         wdog_cnt_q;
   logic                  wdog_expired_q;
   logic [15:0]           cfg_req_q;
   logic [15:0]           baud_q;
   logic [15:0]           link_baud_q;
   logic                  link_cfg_q;
   logic                  link_load_q;
   logic [7:0]            msg_cnt_q;
   logic [4:0]            irq_stat_q;
   logic [4:0]            irq_mask_q;
   logic                  sys_q;
   logic                  pwr_q;
   logic                  ack_q;
   logic [31:0]           rdata_q;
   mhsm_pkg::mhsm_digit_t digit_q;
   mhsm_pkg::mhsm_evt_t   evt;
   mhsm_pkg::mhsm_digit_t digit_d;
   logic [5:0]            idx;
   logic                  acc;
   logic                  wr_acc;
   logic                  cfg_take;
   logic                  st_pass;

   assign idx      = avs_address[7:2];
   assign st_pass  = (st_q == mhsm_pkg::MHSM_ST_PASS);
   // once the watchdog trips, the host gets zeros and writes are dropped
   // host access blocked
   assign acc      = ack_q & ~wdog_expired_q;
   assign wr_acc   = avs_write & acc;
   assign cfg_take = st_pass & (cfg_req_q == `MHSM_CFG_UPDATE);

   // ****************************************************************
   // local watchdog
   // ****************************************************************
   // counts from reset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wdog_cnt_q     <= '0;
         wdog_expired_q <= 1'b0;
      end
      else if (!wdog_expired_q)
      begin
         if (wdog_kick)
            wdog_cnt_q <= '0;
         else if (wdog_cnt_q == WDOG_LAST)
            wdog_expired_q <= 1'b1;
         else
            wdog_cnt_q <= wdog_cnt_q + 1'b1;
      end
   end

   assign cpu_halt_irq    = wdog_expired_q;
   assign host_mem_enable = ~wdog_expired_q;
   assign rx_data_enable  = ~sys_wdog_fail & ~wdog_expired_q;
   assign status_lamp     = st_pass & ~wdog_expired_q;

   // ****************************************************************
   // self-test sequencer
   // ****************************************************************
   // starts at reset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q        <= mhsm_pkg::MHSM_ST_RUN;
         st_unit_q   <= 4'h0;
         fail_code_q <= 4'h0;
      end
      else
      begin
         case (st_q)
            mhsm_pkg::MHSM_ST_RUN:
            begin
               if (st_ack && st_fail)
               begin
                  st_q        <= mhsm_pkg::MHSM_ST_HALT;
                  fail_code_q <= (st_unit_q == `MHSM_UNIT_LAST) ?
                                 `MHSM_CODE_B : st_unit_q;
               end
               else if (st_ack && st_unit_q == `MHSM_UNIT_LAST)
                  st_q <= mhsm_pkg::MHSM_ST_PASS;
               else if (st_ack)
                  st_unit_q <= st_unit_q + 4'h1;
            end
            mhsm_pkg::MHSM_ST_PASS:
               st_q <= mhsm_pkg::MHSM_ST_PASS;
            mhsm_pkg::MHSM_ST_HALT:
               st_q <= mhsm_pkg::MHSM_ST_HALT;
            default:
               st_q <= mhsm_pkg::MHSM_ST_HALT;
         endcase
      end
   end

   assign st_req  = (st_q == mhsm_pkg::MHSM_ST_RUN);
   assign st_unit = st_unit_q;

   // ****************************************************************
   // fault digit
   // ****************************************************************
   // power fail outranks all; test codes outrank status codes
   always_comb
   begin
      digit_d = '{blank: 1'b1, code: 4'h0};
      if (power_fail)
         digit_d = '{blank: 1'b0, code: `MHSM_CODE_PWR};
      else if (st_q == mhsm_pkg::MHSM_ST_HALT)
         digit_d = '{blank: 1'b0, code: fail_code_q};
      else if (st_pass && sys_wdog_fail)
         digit_d = '{blank: 1'b0, code: `MHSM_CODE_SYS};
      else if (st_pass && !link_cfg_q)
         digit_d = '{blank: 1'b0, code: `MHSM_CODE_C};
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         digit_q <= '{blank: 1'b1, code: 4'h0};
      else
         digit_q <= digit_d;
   end

   assign digit = digit_q;

   // ****************************************************************
   // link setup registers
   // ****************************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_req_q   <= 16'h0000;
         baud_q      <= `MHSM_BAUD_DEFAULT;
         link_baud_q <= `MHSM_BAUD_DEFAULT;
         link_cfg_q  <= 1'b0;
         link_load_q <= 1'b0;
      end
      else
      begin
         link_load_q <= cfg_take;
         if (cfg_take)
         begin
            link_baud_q <= baud_q;
            link_cfg_q  <= 1'b1;
         end
         // host write of a fresh request beats the poll clear
         if (wr_acc && idx == `MHSM_REG_CFG_REQ && avs_byteenable[0])
            cfg_req_q <= avs_writedata[15:0];
         else if (cfg_take)
            cfg_req_q <= 16'h0000;
         if (wr_acc && idx == `MHSM_REG_BAUD && avs_byteenable[0])
            baud_q <= avs_writedata[15:0];
      end
   end

   assign link_baud = link_baud_q;
   assign link_load = link_load_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         msg_cnt_q <= 8'h00;
      else if (msg_arrive && rx_data_enable)
         msg_cnt_q <= msg_cnt_q + 8'h01;
   end

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   assign evt.pwr  = power_fail & ~pwr_q;
   assign evt.sys  = sys_wdog_fail & ~sys_q;
   assign evt.cfg  = cfg_take;
   assign evt.fail = (st_q == mhsm_pkg::MHSM_ST_RUN) & st_ack & st_fail;
   assign evt.wdog = ~wdog_expired_q & ~wdog_kick &
                     (wdog_cnt_q == WDOG_LAST);

   // a new event in the clearing read's cycle stays set
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_stat_q <= 5'h00;
         irq_mask_q <= 5'h00;
         pwr_q      <= 1'b0;
         sys_q      <= 1'b0;
      end
      else
      begin
         pwr_q <= power_fail;
         sys_q <= sys_wdog_fail;
         // clears only the bits the read returned; later events survive
         if (avs_read && acc && idx == `MHSM_REG_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~rdata_q[4:0]) | evt;
         else
            irq_stat_q <= irq_stat_q | evt;
         if (wr_acc && idx == `MHSM_REG_IRQ_MASK && avs_byteenable[0])
            irq_mask_q <= avs_writedata[4:0];
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ****************************************************************
   // avalon-mm slave, one wait state per access
   // ****************************************************************
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (avs_read && !ack_q)
         begin
            rdata_q <= 32'h0000_0000;
            if (!wdog_expired_q)
            begin
               case (idx)
                  `MHSM_REG_LINK_STAT:
                     rdata_q[15:0] <= link_cfg_q ? `MHSM_LINK_OK : 16'h0;
                  `MHSM_REG_MSG_CNT:  rdata_q[7:0]  <= msg_cnt_q;
                  `MHSM_REG_CFG_REQ:  rdata_q[15:0] <= cfg_req_q;
                  `MHSM_REG_BAUD:     rdata_q[15:0] <= baud_q;
                  `MHSM_REG_IRQ_STAT: rdata_q[4:0]  <= irq_stat_q;
                  `MHSM_REG_IRQ_MASK: rdata_q[4:0]  <= irq_mask_q;
                  default:            rdata_q       <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   assign avs_readdata = rdata_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_wdog_trip;
      $rose(wdog_expired_q) |-> $past(wdog_cnt_q) == WDOG_LAST &&
                                !$past(wdog_kick);
   endproperty
   a_wdog_trip: assert property (p_wdog_trip)
      else $error("watchdog tripped early");

   property p_halt;
      $rose(wdog_expired_q) |-> cpu_halt_irq [*3];
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt interrupt not held");

   property p_block;
      $past(wdog_expired_q) && avs_read && !avs_waitrequest
         |-> avs_readdata == 32'h0000_0000;
   endproperty
   a_block: assert property (p_block)
      else $error("read served after watchdog trip");

   property p_lamp;
      status_lamp == (!cpu_halt_irq && !st_req &&
                      st_q != mhsm_pkg::MHSM_ST_HALT);
   endproperty
   a_lamp: assert property (p_lamp)
      else $error("lamp lit while unhealthy");

   property p_step;
      st_req && st_ack && !st_fail && st_unit_q != `MHSM_UNIT_LAST
         |=> st_req && st_unit_q == $past(st_unit_q) + 4'h1;
   endproperty
   a_step: assert property (p_step)
      else $error("self-test did not advance");

   property p_fail_code;
      st_req && st_ack && st_fail && !power_fail
         |=> ##1 !digit_q.blank && digit_q.code ==
             (($past(st_unit_q, 2) == `MHSM_UNIT_LAST) ? `MHSM_CODE_B
              : $past(st_unit_q, 2)) || $past(power_fail);
   endproperty
   a_fail_code: assert property (p_fail_code)
      else $error("wrong failing unit code");

   property p_hold;
      st_q == mhsm_pkg::MHSM_ST_HALT |=> st_q == mhsm_pkg::MHSM_ST_HALT
                                         && $stable(fail_code_q) && !st_req;
   endproperty
   a_hold: assert property (p_hold)
      else $error("sequence left failure");

   property p_code_c;
      st_pass && !link_cfg_q && !power_fail && !sys_wdog_fail
         |=> digit_q.code == `MHSM_CODE_C && !digit_q.blank;
   endproperty
   a_code_c: assert property (p_code_c)
      else $error("code C missing");

   property p_pwr;
      power_fail |=> digit_q.code == `MHSM_CODE_PWR && !digit_q.blank;
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("power fail code missing");

   property p_cfg;
      cfg_take && !power_fail && !sys_wdog_fail
         |=> link_cfg_q && link_baud_q == $past(baud_q) && link_load
             ##1 (digit_q.blank || $past(power_fail) || $past(sys_wdog_fail));
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("configuration not accepted");

   property p_msg;
      msg_arrive && rx_data_enable |=> msg_cnt_q == $past(msg_cnt_q) + 8'h01;
   endproperty
   a_msg: assert property (p_msg)
      else $error("message counter did not advance");

   property p_sys;
      sys_wdog_fail |-> !rx_data_enable ##1 $stable(msg_cnt_q);
   endproperty
   a_sys: assert property (p_sys)
      else $error("rx data not withheld");

   c_pass: cover property (st_req ##1 st_pass);
   c_cfg:  cover property ($rose(link_cfg_q));
   c_halt: cover property (st_req && st_ack && st_fail ##2 !digit_q.blank);
   c_wdog: cover property ($rose(wdog_expired_q));
   c_irq:  cover property ($rose(irq));

endmodule
`default_nettype wire

// >>> hw/mhsm_regs.svh
/*
 Register indices, codes and timing figures of the health monitor.
 Assumes word-indexed registers; byte address is four times the index.
*/
`ifndef MHSM_REGS_SVH
`define MHSM_REGS_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define MHSM_REG_LINK_STAT 6'h04
`define MHSM_REG_MSG_CNT   6'h0E
`define MHSM_REG_CFG_REQ   6'h14
`define MHSM_REG_BAUD      6'h15
`define MHSM_REG_IRQ_STAT  6'h28
`define MHSM_REG_IRQ_MASK  6'h29

// ****************************************************************
// values
// ****************************************************************
`define MHSM_CFG_UPDATE    16'h00FF
`define MHSM_BAUD_DEFAULT  16'h11F8
`define MHSM_LINK_OK       16'h0001
`define MHSM_UNIT_LAST     4'hA
`define MHSM_CODE_B        4'hB
`define MHSM_CODE_C        4'hC
`define MHSM_CODE_SYS      4'hE
`define MHSM_CODE_PWR      4'hF

// ****************************************************************
// timing
// ****************************************************************
`define MHSM_CLK_MHZ       100
`define MHSM_WDOG_TIME_MS  100

`endif

// >>> hw/mhsm_pkg.sv
/*
 Types of the health monitor: self-test states, display digit, events.
 Assumes mhsm_regs.svh supplies the numeric constants.
*/
package mhsm_pkg;

   typedef enum logic [2:0]
   {
      MHSM_ST_RUN  = 3'b001,
      MHSM_ST_PASS = 3'b010,
      MHSM_ST_HALT = 3'b100
   } mhsm_st_t;

   typedef struct packed
   {
      logic       blank;
      logic [3:0] code;
   } mhsm_digit_t;

   typedef struct packed
   {
      logic pwr;
      logic sys;
      logic cfg;
      logic fail;
      logic wdog;
   } mhsm_evt_t;

endpackage

// >>> tb/mhsm_st_resp.sv
/*
 Self-test responder model standing beside the health monitor.
 Assumes st_req and st_unit come from the monitor; a fail_unit above
 10 never fails, dly sets the wait before each answer.
*/
`timescale 1ns/100ps
`default_nettype none

module mhsm_st_resp
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // request side
   input  wire logic       st_req,
   input  wire logic [3:0] st_unit,
   // answer side
   output logic            st_ack,
   output logic            st_fail,
   // scenario control
   input  wire logic [3:0] fail_unit,
   input  wire logic [3:0] dly
);
   logic [3:0] cnt_q;

   // ****************************************************************
   // answer
   // ****************************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q   <= 4'h0;
         st_ack  <= 1'h0;
         st_fail <= 1'h0;
      end
      else if (st_req && !st_ack && cnt_q == dly)
      begin
         cnt_q   <= 4'h0;
         st_ack  <= 1'h1;
         st_fail <= (st_unit == fail_unit);
      end
      else
      begin
         cnt_q   <= (st_req && !st_ack) ? cnt_q + 4'h1 : 4'h0;
         st_ack  <= 1'h0;
         // meaningless between answers, so never left at a stale value
         st_fail <= ~st_fail;
      end
   end
endmodule

`default_nettype wire

// >>> tb/tb_module_health_status_monitor.sv
/*
 Self-checking bench of the health monitor: register access over
 Avalon-MM, self-test pass and fail runs, link setup, panel codes.
 Assumes mhsm_regs.svh on the include path and the responder model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mhsm_regs.svh"

`define CHK(g, e) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end

module tb_module_health_status_monitor;
   logic        clk = 1'h0;
   logic        reset_n, avs_read, avs_write, avs_waitrequest, irq;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable, st_unit, fail_unit, dly, code_e;
   logic        wdog_kick, sys_wdog_fail, power_fail, msg_arrive;
   logic        cpu_halt_irq, host_mem_enable, rx_data_enable;
   logic        st_req, st_ack, st_fail, link_load, status_lamp;
   logic [15:0] link_baud;
   mhsm_pkg::mhsm_digit_t digit;
   logic [3:0]  units [7] = '{4'h0, 4'h2, 4'h4, 4'h7, 4'h8, 4'h9, 4'hA};
   int          error_cnt = 0;
   int          n_checks = 0;
   int          load_cnt = 0;

   mhsm_monitor #(.WDOG_CYCLES(64)) dut_u
   (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .wdog_kick(wdog_kick), .sys_wdog_fail(sys_wdog_fail),
      .power_fail(power_fail), .msg_arrive(msg_arrive),
      .cpu_halt_irq(cpu_halt_irq), .host_mem_enable(host_mem_enable),
      .rx_data_enable(rx_data_enable), .st_req(st_req),
      .st_unit(st_unit), .st_ack(st_ack), .st_fail(st_fail),
      .link_baud(link_baud), .link_load(link_load),
      .status_lamp(status_lamp), .digit(digit)
   );

   mhsm_st_resp resp_u
   (
      .clk(clk), .reset_n(reset_n), .st_req(st_req), .st_unit(st_unit),
      .st_ack(st_ack), .st_fail(st_fail), .fail_unit(fail_unit),
      .dly(dly)
   );

   initial
   begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (link_load === 1'h1)
         load_cnt <= load_cnt + 1;
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic bus(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd);
      avs_address   <= {idx, 2'h0};
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= wd;
      // no cycle count assumed; only the bench watchdog ends a hung wait
      do
      begin
         @(posedge clk);
      end
      while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] e);
      bus(1'h0, idx, 32'h0);
      `CHK(rd, e)
   endtask

   task automatic pulse_msg();
      msg_arrive <= 1'h1;
      @(posedge clk);
      msg_arrive <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (st_req !== 1'h0 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 200)
         error_cnt++;
      repeat (2) @(posedge clk);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ****************************************************************
   // sequence
   // ****************************************************************
   initial
   begin
      {avs_read, avs_write, msg_arrive, sys_wdog_fail, power_fail} = 5'h00;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      wdog_kick = 1'h1;
      fail_unit = 4'hF;
      dly = 4'h0;
      reset_n = 1'h0;
      repeat (6) @(posedge clk);
      `CHK(link_baud, `MHSM_BAUD_DEFAULT)
      `CHK(status_lamp, 1'h0)
      reset_n <= 1'h1;
      @(posedge clk);
      `CHK(st_req, 1'h1)
      wait_done();
      `CHK(status_lamp, 1'h1)
      `CHK(digit, 5'h0C)
      rd_chk(`MHSM_REG_LINK_STAT, 32'h0);
      bus(1'h1, 6'h3F, 32'h5A5A);
      rd_chk(6'h3F, 32'h0);
      bus(1'h1, `MHSM_REG_IRQ_MASK, 32'h4);
      bus(1'h1, `MHSM_REG_BAUD, 32'h4B00);
      bus(1'h1, `MHSM_REG_CFG_REQ, {16'h0, `MHSM_CFG_UPDATE});
      repeat (3) @(posedge clk);
      `CHK(link_baud, 16'h4B00)
      `CHK(load_cnt, 1)
      `CHK(digit.blank, 1'h1)
      `CHK(irq, 1'h1)
      rd_chk(`MHSM_REG_LINK_STAT, {16'h0, `MHSM_LINK_OK});
      rd_chk(`MHSM_REG_CFG_REQ, 32'h0);
      rd_chk(`MHSM_REG_IRQ_STAT, 32'h4);
      `CHK(irq, 1'h0)
      // a write with its low lane disabled must leave the rate alone
      avs_byteenable <= 4'h0;
      bus(1'h1, `MHSM_REG_BAUD, 32'h1234);
      avs_byteenable <= 4'hF;
      rd_chk(`MHSM_REG_BAUD, 32'h4B00);
      repeat (3) pulse_msg();
      rd_chk(`MHSM_REG_MSG_CNT, 32'h3);
      sys_wdog_fail <= 1'h1;
      repeat (2) @(posedge clk);
      `CHK(digit, 5'h0E)
      `CHK(rx_data_enable, 1'h0)
      `CHK(status_lamp, 1'h1)
      pulse_msg();
      rd_chk(`MHSM_REG_MSG_CNT, 32'h3);
      `CHK(irq, 1'h0)
      power_fail <= 1'h1;
      repeat (2) @(posedge clk);
      `CHK(digit, 5'h0F)
      rd_chk(`MHSM_REG_IRQ_STAT, 32'h18);
      sys_wdog_fail <= 1'h0;
      power_fail <= 1'h0;
      repeat (2) @(posedge clk);
      `CHK(digit.blank, 1'h1)
      `CHK(rx_data_enable, 1'h1)
      // no service from here on: the watchdog must run out by itself
      wdog_kick <= 1'h0;
      repeat (50) @(posedge clk);
      `CHK(cpu_halt_irq, 1'h0)
      repeat (30) @(posedge clk);
      `CHK(cpu_halt_irq, 1'h1)
      `CHK(host_mem_enable, 1'h0)
      `CHK(status_lamp, 1'h0)
      rd_chk(`MHSM_REG_BAUD, 32'h0);
      wdog_kick <= 1'h1;
      dly <= 4'h2;
      foreach (units[i])
      begin
         fail_unit <= units[i];
         code_e = (units[i] == 4'hA) ? `MHSM_CODE_B : units[i];
         reset_n <= 1'h0;
         repeat (6) @(posedge clk);
         reset_n <= 1'h1;
         @(posedge clk);
         wait_done();
         `CHK(digit, {1'h0, code_e})
         `CHK(status_lamp, 1'h0)
         repeat (20) @(posedge clk);
         `CHK(st_unit, units[i])
         `CHK(digit.code, code_e)
         rd_chk(`MHSM_REG_IRQ_STAT, 32'h2);
      end
      bus(1'h1, `MHSM_REG_BAUD, 32'h0960);
      bus(1'h1, `MHSM_REG_CFG_REQ, {16'h0, `MHSM_CFG_UPDATE});
      repeat (3) @(posedge clk);
      `CHK(link_baud, `MHSM_BAUD_DEFAULT)
      `CHK(load_cnt, 1)
      summarize();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      summarize();
   end
endmodule

`default_nettype wire
